// ===== src/flq_region_info.sv
// AHB-Lite slave serving the region 1 query table and its decoded view
//
// Behaviour
// [RULE1] Each block type returns its least erase cycle count in thousands.
// [RULE2] Type 1 bits per cell sit in bits 3:0; bit 4 flags ECC, 7:5 spare.
// [RULE3] Type 2 bits per cell sit in bits 3:0; bit 4 flags ECC, 7:5 spare.
// [RULE4] Type 1 access byte: page read, sync read, sync write, rest spare.
// [RULE5] Type 2 access byte carries the same three flags in bits 2:0.
// [RULE6] Type 1 region field holds exponent x; region size is 2^x bytes.
// [RULE7] With bit 15 of the region field set, the exponent is ignored.
// [RULE8] Valid size sits in bits 23:16 and invalid size in bits 39:32.
// [RULE9] With bit 47 set, both control mode sizes are ignored.
// [RULE10] Type 2 field bits 15:0 hold y; the block count is y plus one.
// [RULE11] Type 2 bits 31:16 hold z, block size z times 256 bytes. The decoded size reads zero unless BOTTOM_PARAM is set.
// [RULE12] Writes to table locations never change what is read back.
`timescale 1ns/1ps
`default_nettype none
module flq_region_info
	import flq_pkg::*;
#(
	parameter logic [15:0] T1_ENDUR     = FLQ_T1_ENDUR_DEF,
	parameter logic [7:0]  T1_CELL      = FLQ_T1_CELL_DEF,
	parameter logic [7:0]  T1_CAPS      = FLQ_T1_CAPS_DEF,
	parameter logic [47:0] T1_REGION    = FLQ_T1_REGION_DEF,
	parameter logic [31:0] T2_GEOM      = FLQ_T2_GEOM_DEF,
	parameter logic [15:0] T2_ENDUR     = FLQ_T2_ENDUR_DEF,
	parameter logic [7:0]  T2_CELL      = FLQ_T2_CELL_DEF,
	parameter logic [7:0]  T2_CAPS      = FLQ_T2_CAPS_DEF,
	parameter logic        BOTTOM_PARAM = 1'b1
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata
);

	// Masks a size byte that legacy operation makes meaningless
	function automatic logic [31:0] flq_unless_legacy(
		input logic [7:0] value,
		input logic       legacy
	);
		return legacy ? 32'h0000_0000 : {24'h00_0000, value};
	endfunction : flq_unless_legacy

	// Converts a thousands count to plain erase cycles
	function automatic logic [31:0] flq_cycles(input logic [15:0] value);
		return 32'({16'h0000, value} * FLQ_ENDUR_UNIT);
	endfunction : flq_cycles

	// Table image, lowest location in the low byte
	localparam logic [8*FLQ_TABLE_LEN-1:0] TABLE_IMG = {
		// [RULE5] type 2 capabilities
		T2_CAPS,
		// [RULE3] type 2 cell bits
		T2_CELL,
		// [RULE1] type 2 endurance
		T2_ENDUR,
		// [RULE10] type 2 geometry
		T2_GEOM,
		// [RULE8] type 1 region field
		T1_REGION,
		// [RULE4] type 1 capabilities
		T1_CAPS,
		// [RULE2] type 1 cell bits
		T1_CELL,
		// [RULE1] type 1 endurance
		T1_ENDUR
	};

	flq_rom_if rom_bus ();

	flq_query_rom #(
		.TABLE_IMG (TABLE_IMG)
	) u_rom (
		.hclk    (hclk),
		.hresetn (hresetn),
		.port    (rom_bus.rom)
	);

	flq_state_t  state;
	logic [8:0]  addr_idx;
	logic        addr_ok;
	logic        is_write;
	flq_dsel_t   ctrl_sel;
	logic        accept;
	logic        req_ok;
	logic [31:0] decode_val;
	logic [31:0] next_hrdata;

	// hsize is not checked: only whole words are ever issued
	assign accept = hsel && htrans[1] && hready && (state == FLQ_ST_IDLE);
	assign req_ok = (haddr[31:11] == 21'h00_0000) && (haddr[1:0] == 2'b00);
	assign rom_bus.index = addr_idx;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= FLQ_ST_IDLE;
		end else begin
			case (state)
				FLQ_ST_IDLE: begin
					if (accept) begin
						state <= FLQ_ST_FETCH;
					end
				end
				FLQ_ST_FETCH: begin
					state <= FLQ_ST_LOAD;
				end
				FLQ_ST_LOAD: begin
					state <= FLQ_ST_IDLE;
				end
				default: begin
					state <= FLQ_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_idx <= 9'h000;
			addr_ok  <= 1'b0;
			is_write <= 1'b0;
		end else if (accept) begin
			addr_idx <= haddr[10:2];
			addr_ok  <= req_ok;
			is_write <= hwrite;
		end
	end

	// [RULE12] only helper control writable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_sel <= flq_dsel_t'(FLQ_CTRL_RST);
		end else if (state == FLQ_ST_LOAD && is_write && addr_ok
			&& addr_idx == FLQ_IDX_CTRL) begin
			ctrl_sel <= flq_dsel_t'(hwdata[2:0]);
		end
	end

	// Decoded view of the fields, so software need not parse bytes
	always_comb begin
		case (ctrl_sel)
			FLQ_DSEL_T1_CYCLES: begin
				// [RULE1] thousands to cycles
				decode_val = flq_cycles(T1_ENDUR);
			end
			FLQ_DSEL_T1_REGION: begin
				// [RULE7] legacy hides exponent
				if (T1_REGION[FLQ_LEGACY_LO]) begin
					decode_val = 32'h0000_0000;
				// [RULE6] aligned size two to x
				end else if (T1_REGION[FLQ_EXP_LSB +: 8] > 8'h1F) begin
					decode_val = 32'hFFFF_FFFF;
				end else begin
					decode_val = 32'h0000_0001
						<< T1_REGION[FLQ_EXP_LSB +: 5];
				end
			end
			FLQ_DSEL_T1_VALID: begin
				// [RULE9] legacy hides valid size
				decode_val = flq_unless_legacy(
					T1_REGION[FLQ_VALID_LSB +: 8],
					T1_REGION[FLQ_LEGACY_HI]);
			end
			FLQ_DSEL_T1_INVAL: begin
				// [RULE9] legacy hides invalid size
				decode_val = flq_unless_legacy(
					T1_REGION[FLQ_INVALID_LSB +: 8],
					T1_REGION[FLQ_LEGACY_HI]);
			end
			FLQ_DSEL_T2_COUNT: begin
				// [RULE10] count is y plus one
				decode_val = {16'h0000, T2_GEOM[FLQ_COUNT_LSB +: 16]}
					+ 32'h0000_0001;
			end
			FLQ_DSEL_T2_SIZE: begin
				// [RULE11] size in bytes, z times 256, if BOTTOM_PARAM, else zero
				decode_val = BOTTOM_PARAM
					? {8'h00, T2_GEOM[FLQ_SIZE_LSB +: 16], 8'h00}
					: 32'h0000_0000;
			end
			FLQ_DSEL_T2_CYCLES: begin
				decode_val = flq_cycles(T2_ENDUR);
			end
			default: begin
				decode_val = 32'h0000_0000;
			end
		endcase
	end

	// Unmapped words read as zero with an OKAY answer
	always_comb begin
		if (!addr_ok || is_write) begin
			next_hrdata = 32'h0000_0000;
		end else if (rom_bus.hit) begin
			next_hrdata = {24'h00_0000, rom_bus.data};
		end else if (addr_idx == FLQ_IDX_CTRL) begin
			next_hrdata = {29'h0000_0000, ctrl_sel};
		end else if (addr_idx == FLQ_IDX_DECODE) begin
			next_hrdata = decode_val;
		end else begin
			next_hrdata = 32'h0000_0000;
		end
	end

	// Two wait states give the table memory time to register its byte
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
		end else if (accept) begin
			hreadyout <= 1'b0;
		end else if (state == FLQ_ST_LOAD) begin
			hreadyout <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (state == FLQ_ST_LOAD) begin
			hrdata <= next_hrdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_rd(logic [8:0] idx);
		accept && !hwrite && req_ok && haddr[10:2] == idx;
	endsequence

	sequence s_wr(logic [8:0] idx);
		accept && hwrite && req_ok && haddr[10:2] == idx;
	endsequence

	sequence s_wait_done;
		!hreadyout [*2] ##1 hreadyout;
	endsequence

	property p_rd_val(logic [8:0] idx, logic [31:0] val);
		s_rd(idx) |-> ##1 s_wait_done ##0 hrdata == val;
	endproperty

	chk_wait_states: assert property (accept |-> ##1 s_wait_done)
		else $error("transfer did not end after two wait states");

	chk_t1_endur: assert property ( // [RULE1]
		p_rd_val(FLQ_IDX_T1_ENDUR, {24'h00_0000, T1_ENDUR[7:0]}))
		else $error("type 1 endurance low byte wrong");

	chk_t2_endur: assert property ( // [RULE1]
		p_rd_val(FLQ_IDX_T2_ENDUR + 9'h001,
			{24'h00_0000, T2_ENDUR[15:8]}))
		else $error("type 2 endurance high byte wrong");

	chk_t1_cell: assert property ( // [RULE2]
		p_rd_val(FLQ_IDX_T1_CELL, {24'h00_0000, T1_CELL}))
		else $error("type 1 cell byte wrong");

	chk_t2_cell: assert property ( // [RULE3]
		s_rd(FLQ_IDX_T2_CELL) |-> ##3
		hrdata[FLQ_CELL_MSB:0] == T2_CELL[FLQ_CELL_MSB:0]
		&& hrdata[FLQ_ECC_BIT] == T2_CELL[FLQ_ECC_BIT]
		&& hrdata[31:8] == 24'h00_0000)
		else $error("type 2 cell byte wrong");

	chk_t1_caps: assert property ( // [RULE4]
		p_rd_val(FLQ_IDX_T1_CAPS, {24'h00_0000, T1_CAPS}))
		else $error("type 1 capability byte wrong");

	chk_t2_caps: assert property ( // [RULE5]
		s_rd(FLQ_IDX_T2_CAPS) |-> ##3 hreadyout
		&& hrdata[FLQ_CAP_SYNC_WR:FLQ_CAP_PAGE_RD] == T2_CAPS[2:0])
		else $error("type 2 capability flags wrong");

	chk_t1_exponent: assert property ( // [RULE6]
		p_rd_val(FLQ_IDX_T1_REGION,
			{24'h00_0000, T1_REGION[FLQ_EXP_LSB +: 8]}))
		else $error("region exponent byte wrong");

	chk_ctrl_sizes: assert property ( // [RULE8]
		p_rd_val(FLQ_IDX_T1_REGION + 9'h004,
			{24'h00_0000, T1_REGION[FLQ_INVALID_LSB +: 8]}))
		else $error("invalid size byte wrong");

	chk_legacy_exp: assert property ( // [RULE7]
		s_rd(FLQ_IDX_DECODE) ##0 ctrl_sel == FLQ_DSEL_T1_REGION
		&& T1_REGION[FLQ_LEGACY_LO] |-> ##3 hrdata == 32'h0000_0000)
		else $error("legacy region size not hidden");

	chk_legacy_sizes: assert property ( // [RULE9]
		s_rd(FLQ_IDX_DECODE) ##0 T1_REGION[FLQ_LEGACY_HI]
		&& (ctrl_sel == FLQ_DSEL_T1_VALID
		|| ctrl_sel == FLQ_DSEL_T1_INVAL)
		|-> ##3 hrdata == 32'h0000_0000)
		else $error("legacy control sizes not hidden");

	chk_t2_count: assert property ( // [RULE10]
		s_rd(FLQ_IDX_DECODE) ##0 ctrl_sel == FLQ_DSEL_T2_COUNT
		|-> ##3 hrdata == 32'({16'h0000, T2_GEOM[15:0]} + 32'h0000_0001))
		else $error("type 2 block count wrong");

	chk_t2_size: assert property ( // [RULE11]
		p_rd_val(FLQ_IDX_T2_GEOM + 9'h002,
			{24'h00_0000, T2_GEOM[FLQ_SIZE_LSB +: 8]}))
		else $error("type 2 block size byte wrong");

	chk_table_ro: assert property ( // [RULE12]
		s_wr(FLQ_IDX_T1_CAPS) |=> $stable(ctrl_sel) [*3])
		else $error("table write disturbed writable state");

	chk_ctrl_write: assert property (
		s_wr(FLQ_IDX_CTRL) |-> ##3 ctrl_sel == $past(hwdata[2:0], 1))
		else $error("helper control write lost");

	chk_valid_size: assert property ( // [RULE8]
		p_rd_val(FLQ_IDX_T1_REGION + 9'h002,
			{24'h00_0000, T1_REGION[FLQ_VALID_LSB +: 8]}))
		else $error("valid size byte wrong");

	chk_t2_count_lo: assert property ( // [RULE10]
		p_rd_val(FLQ_IDX_T2_GEOM,
			{24'h00_0000, T2_GEOM[FLQ_COUNT_LSB +: 8]}))
		else $error("type 2 count byte wrong");

	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("slave answered with an error");

	// Reads outside the decoded space must never leak table bytes
	chk_unmapped_zero: assert property ( // out of range reads return zero
		accept && !hwrite && !req_ok |-> ##3 hrdata == 32'h0000_0000)
		else $error("out of range read not zero");

endmodule : flq_region_info
`default_nettype wire

// ===== src/flq_pkg.sv
// Constants, field layout and types for the query region information block
package flq_pkg;

	// Table locations, as query indices; byte address is four times the index
	localparam int unsigned FLQ_IDX_W = 9;
	localparam logic [8:0] FLQ_IDX_T1_ENDUR  = 9'h13A;
	localparam logic [8:0] FLQ_IDX_T1_CELL   = 9'h13C;
	localparam logic [8:0] FLQ_IDX_T1_CAPS   = 9'h13D;
	localparam logic [8:0] FLQ_IDX_T1_REGION = 9'h13E;
	localparam logic [8:0] FLQ_IDX_T2_GEOM   = 9'h144;
	localparam logic [8:0] FLQ_IDX_T2_ENDUR  = 9'h148;
	localparam logic [8:0] FLQ_IDX_T2_CELL   = 9'h14A;
	localparam logic [8:0] FLQ_IDX_T2_CAPS   = 9'h14B;
	localparam logic [8:0] FLQ_IDX_FIRST     = 9'h13A;
	localparam logic [8:0] FLQ_IDX_LAST      = 9'h14B;
	localparam int unsigned FLQ_TABLE_LEN    = 18;
	// Helper registers outside the query table
	localparam logic [8:0] FLQ_IDX_CTRL      = 9'h160;
	localparam logic [8:0] FLQ_IDX_DECODE    = 9'h161;

	// Field positions
	localparam int unsigned FLQ_CELL_MSB      = 3;
	localparam int unsigned FLQ_ECC_BIT       = 4;
	localparam int unsigned FLQ_CAP_PAGE_RD   = 0;
	localparam int unsigned FLQ_CAP_SYNC_RD   = 1;
	localparam int unsigned FLQ_CAP_SYNC_WR   = 2;
	localparam int unsigned FLQ_EXP_LSB       = 0;
	localparam int unsigned FLQ_LEGACY_LO     = 15;
	localparam int unsigned FLQ_VALID_LSB     = 16;
	localparam int unsigned FLQ_INVALID_LSB   = 32;
	localparam int unsigned FLQ_LEGACY_HI     = 47;
	localparam int unsigned FLQ_COUNT_LSB     = 0;
	localparam int unsigned FLQ_SIZE_LSB      = 16;
	localparam logic [31:0] FLQ_ENDUR_UNIT    = 32'h0000_03E8;
	localparam int unsigned FLQ_BLOCK_SHIFT   = 8;

	// Default table contents
	localparam logic [15:0] FLQ_T1_ENDUR_DEF  = 16'h0064;
	localparam logic [7:0]  FLQ_T1_CELL_DEF   = 8'h02;
	localparam logic [7:0]  FLQ_T1_CAPS_DEF   = 8'h03;
	localparam logic [47:0] FLQ_T1_REGION_DEF = 48'h8000_0000_8000;
	localparam logic [31:0] FLQ_T2_GEOM_DEF   = 32'h0200_01FE;
	localparam logic [15:0] FLQ_T2_ENDUR_DEF  = 16'h0064;
	localparam logic [7:0]  FLQ_T2_CELL_DEF   = 8'h02;
	localparam logic [7:0]  FLQ_T2_CAPS_DEF   = 8'h03;

	// Values after reset and bus timing
	localparam logic [2:0]  FLQ_CTRL_RST      = 3'h0;
	localparam int unsigned FLQ_WAIT_CYCLES   = 2;

	typedef enum logic [2:0] {
		FLQ_DSEL_T1_CYCLES = 3'b000,
		FLQ_DSEL_T1_REGION = 3'b001,
		FLQ_DSEL_T1_VALID  = 3'b010,
		FLQ_DSEL_T1_INVAL  = 3'b011,
		FLQ_DSEL_T2_COUNT  = 3'b100,
		FLQ_DSEL_T2_SIZE   = 3'b101,
		FLQ_DSEL_T2_CYCLES = 3'b110
	} flq_dsel_t;

	typedef enum logic [1:0] {
		FLQ_ST_IDLE  = 2'b00,
		FLQ_ST_FETCH = 2'b01,
		FLQ_ST_LOAD  = 2'b10
	} flq_state_t;

endpackage : flq_pkg

// ===== src/flq_rom_if.sv
// Lookup path between the bus slave and the query table memory
`timescale 1ns/1ps
`default_nettype none
interface flq_rom_if;
	logic [8:0] index;
	logic [7:0] data;
	logic       hit;
	modport rom  (input index, output data, output hit);
	modport user (output index, input data, input hit);
endinterface : flq_rom_if
`default_nettype wire

// ===== src/flq_query_rom.sv
// Constant query table with registered read data
`timescale 1ns/1ps
`default_nettype none
module flq_query_rom
	import flq_pkg::*;
#(
	parameter logic [8*FLQ_TABLE_LEN-1:0] TABLE_IMG = '0
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	flq_rom_if.rom    port
);
	logic [8:0] offset;
	logic       in_table;

	assign offset   = port.index - FLQ_IDX_FIRST;
	assign in_table = (port.index >= FLQ_IDX_FIRST)
		&& (port.index <= FLQ_IDX_LAST);

	// No write path exists, so contents cannot change
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port.data <= 8'h00;
			port.hit  <= 1'b0;
		end else begin
			port.hit  <= in_table;
			port.data <= in_table ? TABLE_IMG[8*offset +: 8] : 8'h00;
		end
	end
endmodule : flq_query_rom
`default_nettype wire

// ===== verif/flq_host_model.sv
// Bus master model standing for the host that reads the query table
`timescale 1ns/1ps
`default_nettype none
module flq_host_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        start,
	input  wire logic        wr,
	input  wire logic [31:0] addr,
	input  wire logic [31:0] wdata,
	output var  logic        done,
	output var  logic [31:0] rdata,
	output var  logic        hsel,
	output var  logic [31:0] haddr,
	output var  logic [1:0]  htrans,
	output var  logic        hwrite,
	output var  logic [2:0]  hsize,
	output var  logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	logic [1:0] phase;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase  <= 2'h0;
			done   <= 1'b0;
			rdata  <= 32'h0000_0000;
			hsel   <= 1'b0;
			haddr  <= 32'h0000_0000;
			htrans <= 2'h0;
			hwrite <= 1'b0;
			hsize  <= 3'h2;
			hwdata <= 32'hffff_ffff;
		end else begin
			done <= 1'b0;
			case (phase)
			2'h0: if (start) begin
				hsel   <= 1'b1;
				htrans <= 2'h2;
				haddr  <= addr;
				hwrite <= wr;
				phase  <= 2'h1;
			end
			// Address phase held until the slave is ready
			2'h1: if (hready) begin
				hsel   <= 1'b0;
				htrans <= 2'h0;
				haddr  <= ~haddr;
				hwdata <= wdata;
				phase  <= 2'h2;
			end
			2'h2: if (hready) begin
				rdata  <= hrdata;
				done   <= 1'b1;
				// Released data lines must not look stable
				hwdata <= ~hwdata;
				phase  <= 2'h0;
			end
			default: phase <= 2'h0;
			endcase
		end
	end
endmodule : flq_host_model
`default_nettype wire

// ===== verif/flq_region_info_bench.sv
// Self-checking bench for the query region information slave
`timescale 1ns/1ps
`default_nettype none
module flq_region_info_bench
	import flq_pkg::*;
;
	logic        hclk;
	logic        hresetn = 1'b0;
	logic        start   = 1'b0;
	logic        wr      = 1'b0;
	logic [31:0] addr    = 32'h0000_0000;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        done;
	logic [31:0] rdata;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [31:0] lfsr_q  = 32'h0000_ad85;
	logic [7:0]  img[$];
	int          fail_count = 0;
	int          n_checks   = 0;

	flq_region_info DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata));

	flq_host_model host (.hclk(hclk), .hresetn(hresetn), .start(start),
		.wr(wr), .addr(addr), .wdata(wdata), .done(done), .rdata(rdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next

	function automatic logic [31:0] ba(input logic [8:0] idx);
		return {21'h0, idx, 2'b00};
	endfunction : ba

	// Reader's view of the decoded fields
	function automatic logic [31:0] dec_exp(input int s);
		logic [47:0] r;
		logic [31:0] g;
		r = FLQ_T1_REGION_DEF;
		g = FLQ_T2_GEOM_DEF;
		case (s)
		0: return 32'(int'(FLQ_T1_ENDUR_DEF) * 1000);
		1: return r[15] ? 32'h0 : (r[7:0] > 31 ? '1 : 32'h1 << r[7:0]);
		2: return r[47] ? 32'h0 : 32'(r[23:16]);
		3: return r[47] ? 32'h0 : 32'(r[39:32]);
		4: return 32'(int'(g[15:0]) + 1);
		5: return 32'(int'(g[31:16]) * 256);
		6: return 32'(int'(FLQ_T2_ENDUR_DEF) * 1000);
		default: return 32'h0;
		endcase
	endfunction : dec_exp

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		int k;
		@(posedge hclk);
		wr    <= w;
		addr  <= a;
		wdata <= d;
		start <= 1'b1;
		@(posedge hclk);
		start <= 1'b0;
		k = 0;
		while (k < 20 && done !== 1'b1) begin
			@(posedge hclk);
			#1;
			k++;
		end
		if (k == 20) begin
			fail_count++;
			test_done();
		end
		check("response", {31'h0, hresp}, 32'h0);
	endtask : xfer

	task automatic scan(input string tname);
		int i;
		logic [47:0] reg48;
		logic [31:0] geo;
		reg48 = '0;
		geo = '0;
		for (i = 0; i < 18; i++) begin
			xfer(1'b0, ba(FLQ_IDX_FIRST + 9'(i)), 32'h0000_0000);
			check("table byte", rdata, {24'h0, img[i]});
			if (i == 3 || i == 17) begin
				check("caps spare", 32'(rdata[7:3]), 32'h0);
			end
			if (i >= 4 && i < 10) reg48[8*(i-4) +: 8] = rdata[7:0];
			if (i >= 10 && i < 14) geo[8*(i-10) +: 8] = rdata[7:0];
		end
		check("exponent", 32'(reg48[7:0]), 32'h0);
		check("valid size", 32'(reg48[23:16]), 32'h0);
		check("block count", 32'(int'(geo[15:0]) + 1), 32'h0000_01ff);
		check("block size", 32'(int'(geo[31:16]) * 256), 32'h0002_0000);
		$display("test %s done", tname);
	endtask : scan

	initial begin
		int i;
		img = {FLQ_T1_ENDUR_DEF[7:0], FLQ_T1_ENDUR_DEF[15:8],
			FLQ_T1_CELL_DEF, FLQ_T1_CAPS_DEF};
		for (i = 0; i < 6; i++) img.push_back(FLQ_T1_REGION_DEF[8*i +: 8]);
		for (i = 0; i < 4; i++) img.push_back(FLQ_T2_GEOM_DEF[8*i +: 8]);
		img.push_back(FLQ_T2_ENDUR_DEF[7:0]);
		img.push_back(FLQ_T2_ENDUR_DEF[15:8]);
		img.push_back(FLQ_T2_CELL_DEF);
		img.push_back(FLQ_T2_CAPS_DEF);
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, ba(FLQ_IDX_CTRL), 32'h0000_0000);
		check("control reset", rdata, 32'(FLQ_CTRL_RST));
		scan("table read");
		// Random data at every table place must leave it unchanged
		for (i = 0; i < 18; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			xfer(1'b1, ba(FLQ_IDX_FIRST + 9'(i)), lfsr_q);
		end
		scan("table write");
		xfer(1'b1, ba(9'h150), lfsr_q);
		xfer(1'b0, ba(9'h150), 32'h0000_0000);
		check("unmapped", rdata, 32'h0000_0000);
		xfer(1'b0, 32'h0000_0800 | ba(FLQ_IDX_T1_CELL), 32'h0000_0000);
		check("out of range", rdata, 32'h0000_0000);
		$display("test unmapped done");
		for (i = 0; i < 8; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			xfer(1'b1, ba(FLQ_IDX_CTRL), {lfsr_q[31:3], 3'(i)});
			xfer(1'b0, ba(FLQ_IDX_CTRL), 32'h0000_0000);
			check("control", rdata, 32'(i));
			xfer(1'b0, ba(FLQ_IDX_DECODE), 32'h0000_0000);
			check("decode", rdata, dec_exp(i));
		end
		$display("test decode done");
		test_done();
	end
endmodule : flq_region_info_bench
`default_nettype wire
